// file: core/acfg_defs.svh
// register indices, field positions, reset values and timing figures of the config bank
// assumes inclusion by bare name from every file that needs them
`ifndef ACFG_DEFS_SVH
`define ACFG_DEFS_SVH

`define ACFG_IDX_BURST_COUNT   9'h041
`define ACFG_IDX_DIGITAL_BW    9'h042
`define ACFG_IDX_BURST_PAIR    9'h044
`define ACFG_IDX_OVR_POWER     9'h045
`define ACFG_IDX_SKEW_AB       9'h0a9
`define ACFG_IDX_SKEW_CD       9'h0ac
`define ACFG_IDX_THRESH_LEVEL  9'h0c3
`define ACFG_IDX_THRESH_ENABLE 9'h0c4
`define ACFG_IDX_TUNE_0        9'h0cf
`define ACFG_IDX_TUNE_1        9'h0d4
`define ACFG_IDX_TUNE_2        9'h0d5
`define ACFG_IDX_TUNE_45       9'h0d7
`define ACFG_IDX_TUNE_67       9'h0db
`define ACFG_IDX_TUNE_8_10     9'h0f0
`define ACFG_IDX_SWING_TUNE    9'h0f1
`define ACFG_IDX_IRQ_STATUS    9'h100
`define ACFG_IDX_IRQ_MASK      9'h101

// writable bits of each register; everything else reads zero
`define ACFG_MASK_BURST_COUNT  8'h1f
`define ACFG_MASK_DIGITAL_BW   8'h0f
`define ACFG_MASK_BURST_PAIR   8'hc5
`define ACFG_MASK_OVR_POWER    8'h0d
`define ACFG_MASK_SKEW         8'h78
`define ACFG_MASK_THRESH_EN    8'h80
`define ACFG_MASK_TUNE_0       8'h08
`define ACFG_MASK_TUNE_HI      8'h80
`define ACFG_MASK_TUNE_45      8'h0c
`define ACFG_MASK_TUNE_67      8'h30
`define ACFG_MASK_TUNE_8_10    8'h38
`define ACFG_MASK_SWING_TUNE   8'ha3
`define ACFG_MASK_IRQ          8'h03

`define ACFG_RESET_VALUE       8'h00
`define ACFG_THRESH_DEFAULT    8'he6

`define ACFG_POS_AUTO_BURST    0
`define ACFG_POS_HIGH_EXP      1
`define ACFG_POS_LOW_EXP       0
`define ACFG_POS_BW_SELECT     2
`define ACFG_POS_DIGITAL_EN    3
`define ACFG_POS_NS_DISABLE    0
`define ACFG_POS_EMBED_OVR     2
`define ACFG_POS_BURST_AB      6
`define ACFG_POS_BURST_CD      7
`define ACFG_POS_PIN_FUNC      0
`define ACFG_POS_GLOBAL_PD     2
`define ACFG_POS_OVR_SOURCE    3
`define ACFG_POS_SKEW          3
`define ACFG_POS_THRESH_EN     7
`define ACFG_POS_NS_OVERRIDE   7
`define ACFG_POS_IRQ_OVERLOAD  0
`define ACFG_POS_IRQ_WAKE      1

`define ACFG_HIGH_EXP_BASE     5'h0a
`define ACFG_LOW_EXP_BASE      5'h0d
`define ACFG_FULL_SCALE        23'h001fff
`define ACFG_THRESH_DIVISOR    23'h0000ff
`define ACFG_FAST_OVR_LATENCY  7
`define ACFG_CLK_MHZ           100
`define ACFG_WAKE_FULL_US      100
`define ACFG_WAKE_STANDBY_US   10

`endif

// file: core/acfg_pkg.sv
// types and small lookups shared by the config bank files
// assumes acfg_defs.svh is on the include path
package acfg_pkg;

  typedef enum logic [1:0] {
    ACFG_RUN     = 2'b00,
    ACFG_STANDBY = 2'b01,
    ACFG_OFF     = 2'b10,
    ACFG_WAKE    = 2'b11
  } acfg_power_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] idx;
    logic [7:0] wdata;
  } acfg_reg_req_s;

  typedef struct packed {
    logic [7:0] threshold;
    logic       source_normal;
    logic       embed_lsb;
    logic [3:0] burst_chan;
  } acfg_ovr_cfg_s;

  typedef logic signed [9:0] acfg_skew_ps_t;

  function automatic acfg_skew_ps_t acfg_skew_ps(input logic [3:0] code);
    case (code)
      4'h0:    return 10'sh000;
      4'h1:    return -10'sh01e;
      4'h2:    return 10'sh046;
      4'h3:    return 10'sh01e;
      4'h4:    return -10'sh096;
      4'h5:    return -10'sh0b4;
      4'h6:    return -10'sh046;
      4'h7:    return -10'sh06e;
      4'h8:    return 10'sh10e;
      4'h9:    return 10'sh0e6;
      4'ha:    return 10'sh154;
      4'hb:    return 10'sh12c;
      4'hc:    return 10'sh08c;
      4'hd:    return 10'sh06e;
      4'he:    return 10'sh0c8;
      default: return 10'sh0aa;
    endcase
  endfunction

  function automatic logic [31:0] acfg_pow2(input logic [4:0] e);
    return 32'h1 << e;
  endfunction

endpackage

// file: core/acfg_avalon_slave.sv
// avalon-mm slave front end: one wait cycle, then the access completes
// assumes a master that holds its request until waitrequest is low
`timescale 1ns/1ps
`default_nettype none
module acfg_avalon_slave (
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_i,
  input  wire logic [10:0]             avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic                         avs_waitrequest_o,
  output logic [31:0]                  avs_readdata_o,
  output acfg_pkg::acfg_reg_req_s      req_o,
  input  wire logic [7:0]              rdata_i
);
  import acfg_pkg::*;

  logic done_reg;
  logic busy;

  assign busy              = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = busy & ~done_reg;
  // write lands on the edge where waitrequest is seen low
  assign req_o.wr    = avs_write_i & done_reg & avs_byteenable_i[0];
  assign req_o.rd    = avs_read_i & ~done_reg;
  assign req_o.idx   = avs_address_i[10:2];
  assign req_o.wdata = avs_writedata_i[7:0];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy & ~done_reg;
    end
  end

  // read data captured a cycle early so it stands at the completing edge
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0;
    end else if (req_o.rd) begin
      avs_readdata_o <= {24'h0, rdata_i};
    end
  end
endmodule
`default_nettype wire

// file: core/acfg_overload_detect.sv
// per-channel overload detector, overrange select and lsb embedding
// assumes sample_en_i marks one output clock; samples are twos complement
`timescale 1ns/1ps
`default_nettype none
`include "acfg_defs.svh"
module acfg_overload_detect #(
  parameter int CHANNELS = 4,
  parameter int WIDTH    = 14
) (
  input  wire logic                              core_clk_i,
  input  wire logic                              reset_i,
  input  wire logic                              sample_en_i,
  input  wire logic [CHANNELS-1:0][WIDTH-1:0]    sample_data_i,
  input  wire logic [CHANNELS-1:0]               normal_ovr_i,
  input  wire acfg_pkg::acfg_ovr_cfg_s           cfg_i,
  output logic [CHANNELS-1:0][WIDTH-1:0]         data_o,
  output logic [CHANNELS-1:0]                    overrange_o,
  output logic                                   fast_event_o
);
  import acfg_pkg::*;

  localparam int LAT = `ACFG_FAST_OVR_LATENCY;

  logic [LAT-1:0][CHANNELS-1:0] fast_pipe_reg;
  logic [CHANNELS-1:0]          trip;
  logic [CHANNELS-1:0]          ovr_sel;

  always_comb begin
    logic [WIDTH-1:0] mag;
    mag = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      mag = sample_data_i[c][WIDTH-1] ? WIDTH'(-sample_data_i[c]) : sample_data_i[c];
      // cross-multiplied so no divider is needed
      trip[c] = (23'(mag) * `ACFG_THRESH_DIVISOR) >
                (`ACFG_FULL_SCALE * 23'(cfg_i.threshold));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fast_pipe_reg <= '0;
    end else if (sample_en_i) begin
      fast_pipe_reg <= {fast_pipe_reg[LAT-2:0], trip};
    end
  end

  assign ovr_sel = cfg_i.source_normal ? normal_ovr_i : fast_pipe_reg[LAT-1];
  assign fast_event_o = sample_en_i & (|fast_pipe_reg[LAT-1]);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      data_o      <= '0;
      overrange_o <= '0;
    end else if (sample_en_i) begin
      overrange_o <= ovr_sel;
      for (int c = 0; c < CHANNELS; c++) begin
        data_o[c] <= sample_data_i[c];
        if (cfg_i.embed_lsb && cfg_i.burst_chan[c]) begin
          data_o[c][0] <= ovr_sel[c];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: core/acfg_regs.sv
// configuration register bank for a quad converter digital back end
// assumes a single 100 mhz clock, avalon-mm master, raw pins for sleep and noise shaping
`timescale 1ns/1ps
`default_nettype none
`include "acfg_defs.svh"
module acfg_regs #(
  parameter int CHANNELS      = 4,
  parameter int WIDTH         = 14,
  parameter int WAKE_FULL_CYC = `ACFG_WAKE_FULL_US * `ACFG_CLK_MHZ
) (
  input  wire logic                           core_clk_i,
  input  wire logic                           reset_i,
  input  wire logic [10:0]                    avs_address_i,
  input  wire logic                           avs_read_i,
  input  wire logic                           avs_write_i,
  input  wire logic [31:0]                    avs_writedata_i,
  input  wire logic [3:0]                     avs_byteenable_i,
  output logic                                avs_waitrequest_o,
  output logic [31:0]                         avs_readdata_o,
  input  wire logic                           sample_en_i,
  input  wire logic [CHANNELS-1:0][WIDTH-1:0] sample_data_i,
  input  wire logic [CHANNELS-1:0]            normal_ovr_i,
  input  wire logic                           noise_shaping_pin_i,
  input  wire logic                           sleep_pin_i,
  output logic [CHANNELS-1:0][WIDTH-1:0]      data_o,
  output logic [CHANNELS-1:0]                 overrange_flag_o,
  output logic [31:0]                         high_res_count_o,
  output logic [31:0]                         low_res_count_o,
  output logic                                auto_burst_o,
  output logic                                long_sample_enable_pair_ab_o,
  output logic                                long_sample_enable_pair_cd_o,
  output logic                                digital_features_enable_o,
  output logic                                noise_shaping_bandwidth_select_o,
  output logic                                noise_shaping_off_o,
  output logic                                global_power_down_o,
  output logic                                standby_o,
  output logic                                power_ready_o,
  output acfg_pkg::acfg_skew_ps_t             out_clock_skew_pair_ab_ps_o,
  output acfg_pkg::acfg_skew_ps_t             out_clock_skew_pair_cd_ps_o,
  output logic                                swing_custom_enable_o,
  output logic [13:0]                         tuning_bits_o,
  output logic                                irq_o
);
  import acfg_pkg::*;

  localparam int          WAKE_STBY_CYC = `ACFG_WAKE_STANDBY_US * `ACFG_CLK_MHZ;
  localparam logic [13:0] FULL_LOAD     = 14'(WAKE_FULL_CYC);
  localparam logic [13:0] STBY_LOAD     = 14'(WAKE_STBY_CYC);

  acfg_reg_req_s req;
  logic [7:0]    rdata;

  logic [7:0] burst_count_reg;
  logic [7:0] digital_bw_reg;
  logic [7:0] burst_pair_reg;
  logic [7:0] ovr_power_reg;
  logic [7:0] skew_ab_reg;
  logic [7:0] skew_cd_reg;
  logic [7:0] thresh_level_reg;
  logic [7:0] thresh_enable_reg;
  logic       thresh_written_reg;
  logic [7:0] tune_0_reg;
  logic [7:0] tune_1_reg;
  logic [7:0] tune_2_reg;
  logic [7:0] tune_45_reg;
  logic [7:0] tune_67_reg;
  logic [7:0] tune_8_10_reg;
  logic [7:0] swing_tune_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] irq_set;
  logic [7:0] thresh_view;

  logic ns_pin_meta_reg;
  logic ns_pin_sync_reg;
  logic sleep_meta_reg;
  logic sleep_sync_reg;

  acfg_power_e power_reg;
  acfg_power_e power_next;
  logic [13:0] wake_cnt_reg;
  logic        pd_req;
  logic        sb_req;
  logic        wake_done;

  acfg_ovr_cfg_s ovr_cfg;
  logic          fast_event;

  acfg_avalon_slave u_slave (
    .core_clk_i        (core_clk_i),
    .reset_i           (reset_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_waitrequest_o (avs_waitrequest_o),
    .avs_readdata_o    (avs_readdata_o),
    .req_o             (req),
    .rdata_i           (rdata)
  );

  // reserved positions are masked off so they always read zero
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      burst_count_reg   <= `ACFG_RESET_VALUE;
      digital_bw_reg    <= `ACFG_RESET_VALUE;
      burst_pair_reg    <= `ACFG_RESET_VALUE;
      ovr_power_reg     <= `ACFG_RESET_VALUE;
      skew_ab_reg       <= `ACFG_RESET_VALUE;
      skew_cd_reg       <= `ACFG_RESET_VALUE;
      thresh_level_reg  <= `ACFG_RESET_VALUE;
      thresh_enable_reg <= `ACFG_RESET_VALUE;
      tune_0_reg        <= `ACFG_RESET_VALUE;
      tune_1_reg        <= `ACFG_RESET_VALUE;
      tune_2_reg        <= `ACFG_RESET_VALUE;
      tune_45_reg       <= `ACFG_RESET_VALUE;
      tune_67_reg       <= `ACFG_RESET_VALUE;
      tune_8_10_reg     <= `ACFG_RESET_VALUE;
      swing_tune_reg    <= `ACFG_RESET_VALUE;
      irq_mask_reg      <= `ACFG_RESET_VALUE;
    end else if (req.wr) begin
      case (req.idx)
        `ACFG_IDX_BURST_COUNT:   burst_count_reg   <= req.wdata & `ACFG_MASK_BURST_COUNT;
        `ACFG_IDX_DIGITAL_BW:    digital_bw_reg    <= req.wdata & `ACFG_MASK_DIGITAL_BW;
        `ACFG_IDX_BURST_PAIR:    burst_pair_reg    <= req.wdata & `ACFG_MASK_BURST_PAIR;
        `ACFG_IDX_OVR_POWER:     ovr_power_reg     <= req.wdata & `ACFG_MASK_OVR_POWER;
        `ACFG_IDX_SKEW_AB:       skew_ab_reg       <= req.wdata & `ACFG_MASK_SKEW;
        `ACFG_IDX_SKEW_CD:       skew_cd_reg       <= req.wdata & `ACFG_MASK_SKEW;
        `ACFG_IDX_THRESH_LEVEL:  thresh_level_reg  <= req.wdata;
        `ACFG_IDX_THRESH_ENABLE: thresh_enable_reg <= req.wdata & `ACFG_MASK_THRESH_EN;
        `ACFG_IDX_TUNE_0:        tune_0_reg        <= req.wdata & `ACFG_MASK_TUNE_0;
        `ACFG_IDX_TUNE_1:        tune_1_reg        <= req.wdata & `ACFG_MASK_TUNE_HI;
        `ACFG_IDX_TUNE_2:        tune_2_reg        <= req.wdata & `ACFG_MASK_TUNE_HI;
        `ACFG_IDX_TUNE_45:       tune_45_reg       <= req.wdata & `ACFG_MASK_TUNE_45;
        `ACFG_IDX_TUNE_67:       tune_67_reg       <= req.wdata & `ACFG_MASK_TUNE_67;
        `ACFG_IDX_TUNE_8_10:     tune_8_10_reg     <= req.wdata & `ACFG_MASK_TUNE_8_10;
        `ACFG_IDX_SWING_TUNE:    swing_tune_reg    <= req.wdata & `ACFG_MASK_SWING_TUNE;
        `ACFG_IDX_IRQ_MASK:      irq_mask_reg      <= req.wdata & `ACFG_MASK_IRQ;
        default: ;
      endcase
    end
  end

  // threshold reads its default while the enable bit is set and software has not yet written a level
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      thresh_written_reg <= 1'b0;
    end else if (req.wr && req.idx == `ACFG_IDX_THRESH_LEVEL) begin
      thresh_written_reg <= 1'b1;
    end
  end

  assign thresh_view = (thresh_enable_reg[`ACFG_POS_THRESH_EN] && !thresh_written_reg)
                       ? `ACFG_THRESH_DEFAULT : thresh_level_reg;

  always_comb begin
    case (req.idx)
      `ACFG_IDX_BURST_COUNT:   rdata = burst_count_reg;
      `ACFG_IDX_DIGITAL_BW:    rdata = digital_bw_reg;
      `ACFG_IDX_BURST_PAIR:    rdata = burst_pair_reg;
      `ACFG_IDX_OVR_POWER:     rdata = ovr_power_reg;
      `ACFG_IDX_SKEW_AB:       rdata = skew_ab_reg;
      `ACFG_IDX_SKEW_CD:       rdata = skew_cd_reg;
      `ACFG_IDX_THRESH_LEVEL:  rdata = thresh_view;
      `ACFG_IDX_THRESH_ENABLE: rdata = thresh_enable_reg;
      `ACFG_IDX_TUNE_0:        rdata = tune_0_reg;
      `ACFG_IDX_TUNE_1:        rdata = tune_1_reg;
      `ACFG_IDX_TUNE_2:        rdata = tune_2_reg;
      `ACFG_IDX_TUNE_45:       rdata = tune_45_reg;
      `ACFG_IDX_TUNE_67:       rdata = tune_67_reg;
      `ACFG_IDX_TUNE_8_10:     rdata = tune_8_10_reg;
      `ACFG_IDX_SWING_TUNE:    rdata = swing_tune_reg;
      `ACFG_IDX_IRQ_STATUS:    rdata = irq_status_reg;
      `ACFG_IDX_IRQ_MASK:      rdata = irq_mask_reg;
      default:                 rdata = 8'h00;
    endcase
  end

  // burst sample counts, exponents zero-extended before the add
  assign high_res_count_o = acfg_pow2(`ACFG_HIGH_EXP_BASE +
                            5'(burst_count_reg[`ACFG_POS_HIGH_EXP +: 4]));
  assign low_res_count_o  = acfg_pow2(`ACFG_LOW_EXP_BASE +
                            5'(burst_count_reg[`ACFG_POS_HIGH_EXP +: 4]) +
                            5'(digital_bw_reg[`ACFG_POS_LOW_EXP +: 2]));
  assign auto_burst_o     = burst_count_reg[`ACFG_POS_AUTO_BURST];

  assign long_sample_enable_pair_ab_o = burst_pair_reg[`ACFG_POS_BURST_AB];
  assign long_sample_enable_pair_cd_o = burst_pair_reg[`ACFG_POS_BURST_CD];

  assign digital_features_enable_o        = digital_bw_reg[`ACFG_POS_DIGITAL_EN];
  assign noise_shaping_bandwidth_select_o = digital_bw_reg[`ACFG_POS_BW_SELECT];

  // pins are asynchronous; first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ns_pin_meta_reg <= 1'b0;
      ns_pin_sync_reg <= 1'b0;
      sleep_meta_reg  <= 1'b0;
      sleep_sync_reg  <= 1'b0;
    end else begin
      ns_pin_meta_reg <= noise_shaping_pin_i;
      ns_pin_sync_reg <= ns_pin_meta_reg;
      sleep_meta_reg  <= sleep_pin_i;
      sleep_sync_reg  <= sleep_meta_reg;
    end
  end

  // pin high asks for noise shaping off, like the register bit
  assign noise_shaping_off_o = swing_tune_reg[`ACFG_POS_NS_OVERRIDE]
                               ? burst_pair_reg[`ACFG_POS_NS_DISABLE]
                               : ns_pin_sync_reg;

  assign pd_req = ovr_power_reg[`ACFG_POS_GLOBAL_PD] |
                  (sleep_sync_reg & ovr_power_reg[`ACFG_POS_PIN_FUNC]);
  assign sb_req = sleep_sync_reg & ~ovr_power_reg[`ACFG_POS_PIN_FUNC];

  always_comb begin
    power_next = power_reg;
    unique case (power_reg)
      ACFG_RUN: begin
        if (pd_req) begin
          power_next = ACFG_OFF;
        end else if (sb_req) begin
          power_next = ACFG_STANDBY;
        end
      end
      ACFG_STANDBY: begin
        if (pd_req) begin
          power_next = ACFG_OFF;
        end else if (!sb_req) begin
          power_next = ACFG_WAKE;
        end
      end
      ACFG_OFF: begin
        if (!pd_req) begin
          power_next = sb_req ? ACFG_STANDBY : ACFG_WAKE;
        end
      end
      ACFG_WAKE: begin
        if (pd_req) begin
          power_next = ACFG_OFF;
        end else if (sb_req) begin
          power_next = ACFG_STANDBY;
        end else if (wake_cnt_reg == 14'h1) begin
          power_next = ACFG_RUN;
        end
      end
    endcase
  end

  assign wake_done = (power_reg == ACFG_WAKE) && (power_next == ACFG_RUN);

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      power_reg <= ACFG_RUN;
    end else begin
      power_reg <= power_next;
    end
  end

  // wake time depends on how deep the block slept
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wake_cnt_reg <= 14'h0;
    end else if (power_next == ACFG_WAKE && power_reg == ACFG_OFF) begin
      wake_cnt_reg <= FULL_LOAD;
    end else if (power_next == ACFG_WAKE && power_reg == ACFG_STANDBY) begin
      wake_cnt_reg <= STBY_LOAD;
    end else if (power_reg == ACFG_WAKE && wake_cnt_reg != 14'h0) begin
      wake_cnt_reg <= wake_cnt_reg - 14'h1;
    end
  end

  assign global_power_down_o = (power_reg == ACFG_OFF);
  assign standby_o           = (power_reg == ACFG_STANDBY);
  assign power_ready_o       = (power_reg == ACFG_RUN);

  assign out_clock_skew_pair_ab_ps_o = acfg_skew_ps(skew_ab_reg[`ACFG_POS_SKEW +: 4]);
  assign out_clock_skew_pair_cd_ps_o = acfg_skew_ps(skew_cd_reg[`ACFG_POS_SKEW +: 4]);

  // the two "do not use" codes fall back to the fixed swing
  assign swing_custom_enable_o = (swing_tune_reg[1:0] == 2'b11);

  // stored only, except the low three bits, which also drive logic here; the analog side interprets these
  assign tuning_bits_o = {swing_tune_reg[5], tune_8_10_reg[5:3], tune_67_reg[5:4],
                          tune_45_reg[3:2], tune_2_reg[7], tune_1_reg[7], tune_0_reg[3],
                          thresh_enable_reg[7], digital_bw_reg[3], burst_pair_reg[0]};

  always_comb begin
    ovr_cfg               = '0;
    ovr_cfg.threshold     = thresh_view;
    ovr_cfg.source_normal = ovr_power_reg[`ACFG_POS_OVR_SOURCE];
    ovr_cfg.embed_lsb     = burst_pair_reg[`ACFG_POS_EMBED_OVR];
    ovr_cfg.burst_chan    = {{2{burst_pair_reg[`ACFG_POS_BURST_CD]}},
                             {2{burst_pair_reg[`ACFG_POS_BURST_AB]}}};
  end

  acfg_overload_detect #(
    .CHANNELS (CHANNELS),
    .WIDTH    (WIDTH)
  ) u_detect (
    .core_clk_i    (core_clk_i),
    .reset_i       (reset_i),
    .sample_en_i   (sample_en_i),
    .sample_data_i (sample_data_i),
    .normal_ovr_i  (normal_ovr_i),
    .cfg_i         (ovr_cfg),
    .data_o        (data_o),
    .overrange_o   (overrange_flag_o),
    .fast_event_o  (fast_event)
  );

  always_comb begin
    irq_set                         = 8'h00;
    irq_set[`ACFG_POS_IRQ_OVERLOAD] = fast_event;
    irq_set[`ACFG_POS_IRQ_WAKE]     = wake_done;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      irq_status_reg <= `ACFG_RESET_VALUE;
    end else if (req.wr && req.idx == `ACFG_IDX_IRQ_STATUS) begin
      irq_status_reg <= (irq_status_reg & ~req.wdata) | irq_set;
    end else begin
      irq_status_reg <= irq_status_reg | irq_set;
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);
endmodule
`default_nettype wire

// file: testbench/acfg_regs_checker.sv
// checker for the config bank, bound to acfg_regs
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module acfg_regs_checker (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic sample_en_i,
  input wire logic [31:0] high_res_count_o,
  input wire logic [31:0] low_res_count_o,
  input wire logic digital_features_enable_o,
  input wire logic long_sample_enable_pair_ab_o,
  input wire logic [3:0] overrange_flag_o,
  input wire logic global_power_down_o,
  input wire logic power_ready_o,
  input wire acfg_pkg::acfg_skew_ps_t out_clock_skew_pair_ab_ps_o,
  input wire logic swing_custom_enable_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // only a completed write may move a setting
  wire logic wdone = avs_write_i && !avs_waitrequest_o;
  hi_count_a: assert property ($onehot(high_res_count_o) && high_res_count_o >= 32'h400
    && high_res_count_o <= 32'h2000000) else $error("high count");
  lo_count_a: assert property ($onehot(low_res_count_o)
    && low_res_count_o >= high_res_count_o << 3 && low_res_count_o <= high_res_count_o << 6)
    else $error("low count");
  dig_write_a: assert property ($changed(digital_features_enable_o) |-> $past(wdone))
    else $error("digital enable moved");
  pair_write_a: assert property ($changed(long_sample_enable_pair_ab_o) |-> $past(wdone))
    else $error("pair enable moved");
  slow_wake_a: assert property (global_power_down_o |=> !power_ready_o)
    else $error("fast wake");
  skew_code_a: assert property (out_clock_skew_pair_ab_ps_o inside {0, -30, 70, 30, -150,
    -180, -70, -110, 270, 230, 340, 300, 140, 110, 200, 170}) else $error("skew value");
  swing_write_a: assert property ($rose(swing_custom_enable_o) |-> $past(wdone))
    else $error("swing moved");
  ovr_hold_a: assert property (!sample_en_i |=> $stable(overrange_flag_o))
    else $error("overrange moved");
endmodule
bind acfg_regs acfg_regs_checker chk_u (.core_clk_i, .reset_i, .avs_write_i, .avs_waitrequest_o,
  .sample_en_i, .high_res_count_o, .low_res_count_o, .digital_features_enable_o,
  .long_sample_enable_pair_ab_o, .overrange_flag_o, .global_power_down_o, .power_ready_o,
  .out_clock_skew_pair_ab_ps_o, .swing_custom_enable_o);
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the config bank
// assumes one 100 mhz clock; checker bound to acfg_regs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acfg_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, se = 0, nsp = 0, slp = 0;
  logic [10:0] adr = 0;
  logic [31:0] wd = 0, rdv, rq, hi, lo;
  logic [3:0][13:0] sd = 0, dat;
  logic [3:0] overrange_flag, nov = 0;
  logic wq, irq, off, gpd, rdy, sw, dig, bw, ab, cd, sb;
  acfg_skew_ps_t sab, scd;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  int sk[16] = '{0, -30, 70, 30, -150, -180, -70, -110, 270, 230, 340, 300, 140, 110, 200, 170};
  logic [8:0] rl[18] = '{9'h041, 9'h042, 9'h044, 9'h045, 9'h0a9, 9'h0ac, 9'h0c3, 9'h0c4,
    9'h0cf, 9'h0d4, 9'h0d5, 9'h0d7, 9'h0db, 9'h0f0, 9'h0f1, 9'h100, 9'h101, 9'h1ff};
  always #5 clk = ~clk;
  // short wake count keeps the run brief
  acfg_regs #(.WAKE_FULL_CYC(50)) dut_u (.core_clk_i(clk), .reset_i(rst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
    .avs_waitrequest_o(wq), .avs_readdata_o(rq), .sample_en_i(se), .sample_data_i(sd),
    .normal_ovr_i(nov), .noise_shaping_pin_i(nsp), .sleep_pin_i(slp), .data_o(dat),
    .overrange_flag_o(overrange_flag), .high_res_count_o(hi), .low_res_count_o(lo), .auto_burst_o(),
    .long_sample_enable_pair_ab_o(ab), .long_sample_enable_pair_cd_o(cd),
    .digital_features_enable_o(dig), .noise_shaping_bandwidth_select_o(bw),
    .noise_shaping_off_o(off), .global_power_down_o(gpd), .standby_o(sb), .power_ready_o(rdy),
    .out_clock_skew_pair_ab_ps_o(sab), .out_clock_skew_pair_cd_ps_o(scd),
    .swing_custom_enable_o(sw), .tuning_bits_o(), .irq_o(irq));
  task automatic ck(input logic [31:0] a, e);
    num_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, a, e);
    end
  endtask
  // request held until waitrequest low, then one idle edge
  task automatic bus(input logic w, input logic [8:0] i, input logic [7:0] d);
    adr <= {i, 2'b00};
    wd <= {24'h0, d};
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wq);
    rdv = rq;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [8:0] i, input logic [7:0] e);
    bus(0, i, 8'h00);
    ck(rdv, {24'h0, e});
  endtask
  task automatic t_reset;
    foreach (rl[n]) rc(rl[n], 8'h00);
    ck(hi, 32'h400);
    ck(lo, 32'h2000);
  endtask
  task automatic t_cnt;
    bus(1, 9'h041, 8'h1e);
    bus(1, 9'h042, 8'h0b);
    bus(1, 9'h0cf, 8'h08);
    rc(9'h0cf, 8'h08);
    ck(hi, 32'h2000000);
    ck(lo, 32'h80000000);
    ck({dig, bw}, 2'b10);
    bus(1, 9'h042, 8'h04);
    ck({dig, bw}, 2'b01);
    ck(lo, 32'h10000000);
  endtask
  task automatic t_pair;
    bus(1, 9'h044, 8'h40);
    ck({cd, ab}, 2'b01);
    bus(1, 9'h044, 8'h81);
    ck({cd, ab}, 2'b10);
    nsp <= 1;
    repeat (4) @(posedge clk);
    ck(off, 1'b1);
    bus(1, 9'h0f1, 8'h80);
    bus(1, 9'h044, 8'h80);
    ck(off, 1'b0);
  endtask
  task automatic t_skew;
    for (int c = 0; c < 16; c++) begin
      bus(1, 9'h0a9, 8'(c << 3));
      ck(sab, sk[c]);
    end
    bus(1, 9'h0ac, 8'h40);
    ck(scd, 32'h10e);
  endtask
  task automatic t_swing;
    bus(1, 9'h0f1, 8'h83);
    ck(sw, 1'b1);
    bus(1, 9'h0f1, 8'h80);
    ck(sw, 1'b0);
  endtask
  task automatic t_pwr;
    slp <= 1;
    repeat (4) @(posedge clk);
    ck({sb, rdy}, 2'b10);
    slp <= 0;
    repeat (990) @(posedge clk);
    ck(rdy, 1'b0);
    repeat (15) @(posedge clk);
    ck(rdy, 1'b1);
    bus(1, 9'h100, 8'h02);
    bus(1, 9'h101, 8'h02);
    bus(1, 9'h045, 8'h04);
    @(posedge clk);
    ck({gpd, rdy}, 2'b10);
    bus(1, 9'h045, 8'h00);
    repeat (40) @(posedge clk);
    ck(rdy, 1'b0);
    repeat (20) @(posedge clk);
    ck({rdy, irq}, 2'b11);
    rc(9'h100, 8'h02);
    bus(1, 9'h100, 8'h02);
    ck(irq, 1'b0);
  endtask
  // over-range sample then eight more pulses
  task automatic t_fast(input logic e);
    se <= 1;
    sd[0] <= 14'h1fff;
    for (int k = 0; k < 9; k++) begin
      @(posedge clk);
      sd[0] <= 14'h0000;
      ck(overrange_flag[0], e && k == 8);
      if (k == 8) ck(dat[0], {13'h0, e});
    end
    se <= 0;
  endtask
  task automatic t_ovr;
    bus(1, 9'h0c4, 8'h80);
    rc(9'h0c3, 8'he6);
    bus(1, 9'h101, 8'h01);
    bus(1, 9'h044, 8'h44);
    t_fast(1'b1);
    rc(9'h100, 8'h01);
    ck(irq, 1'b1);
    bus(1, 9'h100, 8'h01);
    ck(irq, 1'b0);
    bus(1, 9'h0c3, 8'hff);
    t_fast(1'b0);
    bus(1, 9'h045, 8'h08);
    nov <= 4'h1;
    se <= 1;
    @(posedge clk);
    se <= 0;
    @(posedge clk);
    ck(overrange_flag[0], 1'b1);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_reset;
    t_cnt;
    t_pair;
    t_skew;
    t_swing;
    t_pwr;
    t_ovr;
    test_done;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      test_done;
    end
  end
endmodule
`default_nettype wire
